// >>> design/pscc_pkg.sv
// Purpose: Constants, register map and types of the clock multiplier control block
// Assumes: 8-bit registers, one per aligned 32-bit Wishbone word, byte address = index * 4
// Notes:   Indices above the low 30 bits are cut to the word address width

`default_nettype none

package pscc_pkg;
  // ==========================================================================
  // Register indices
  localparam logic [31:0] IDX_MULT_CTL  = 32'hfffff82c;
  localparam logic [31:0] IDX_SFC_A     = 32'h0ffff3f1;
  localparam logic [31:0] IDX_SFC_B     = 32'h0ffff3f2;
  localparam logic [31:0] IDX_LOCK      = 32'h00000100;
  localparam logic [31:0] IDX_LOCKUP    = 32'h00000101;
  localparam logic [31:0] IDX_SPREAD    = 32'h00000102;

  // ==========================================================================
  // Field positions
  localparam int MC_EN_BIT       = 0;
  localparam int MC_SEL_BIT      = 1;
  localparam int SC_EN_BIT       = 0;
  localparam int SC_SEL_BIT      = 1;
  localparam int SFA_HALVE_BIT   = 7;
  localparam int SFA_RDIV_LSB    = 4;
  localparam int SFA_ODIV_LSB    = 2;
  localparam int SFA_RANGE_LSB   = 0;
  localparam int SFB_MOD_BIT     = 7;
  localparam int SFB_DEPTH_LSB   = 4;
  localparam int SFB_PER_LSB     = 0;
  localparam logic [7:0] SFB_WMASK = 8'hf3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SFA_RST     = 8'h00;
  localparam logic [7:0] SFB_RST     = 8'h00;
  localparam logic [2:0] LOCKUP_RST  = 3'h3;
  localparam logic       LOCK_RST    = 1'h1;

  // ==========================================================================
  // Codes and counts
  localparam logic [2:0]  LOCKUP_CODE_12 = 3'h2;
  localparam logic [2:0]  LOCKUP_CODE_13 = 3'h3;
  localparam logic [2:0]  LOCKUP_CODE_14 = 3'h4;
  localparam logic [14:0] LOCKUP_CYC_12  = 15'h1000;
  localparam logic [14:0] LOCKUP_CYC_13  = 15'h2000;
  localparam logic [14:0] LOCKUP_CYC_14  = 15'h4000;
  localparam logic [1:0]  ODIV_CODE_2    = 2'h1;
  localparam logic [1:0]  ODIV_CODE_4    = 2'h2;
  localparam logic [2:0]  ODIV_RATIO_2   = 3'h2;
  localparam logic [2:0]  ODIV_RATIO_4   = 3'h4;
  localparam logic [2:0]  DEPTH_MAX      = 3'h5;
  localparam logic [1:0]  PERIOD_BAD     = 2'h3;

  typedef enum logic {LK_IDLE, LK_COUNT} pscc_lock_state_t;
endpackage : pscc_pkg

`default_nettype wire

// >>> design/pscc_top.sv
// Purpose: Multiplier and spread-spectrum control, lock tracking, reference divider, clock pin
// Assumes: core_clk is the main oscillator; standby and timer inputs are synchronous
// Notes:   Registers on classic Wishbone, one wait state on every access
//
// Decided for this implementation: the Wishbone interface to the registers.

`default_nettype none

module pscc_top #(
  parameter logic [14:0] LOCKUP_CYC_12 = pscc_pkg::LOCKUP_CYC_12,
  parameter logic [14:0] LOCKUP_CYC_13 = pscc_pkg::LOCKUP_CYC_13,
  parameter logic [14:0] LOCKUP_CYC_14 = pscc_pkg::LOCKUP_CYC_14
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [31:0] wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic [31:0]      wb_dat_r,
  output logic             wb_ack,
  // Standby controller and oscillator status
  input  wire logic        stop_mode,
  input  wire logic        intermediate_standby,
  input  wire logic        ost_overflow,
  input  wire logic        intermediate_standby_setup_done,
  input  wire logic        main_osc_stop,
  input  wire logic        subclock_select,
  // System clock output pin
  input  wire logic        sys_clk_level,
  input  wire logic        sys_clk_operable,
  input  wire logic        port_output_mode,
  output logic             clk_out,
  output logic             clk_out_oe,
  // Clock multiplier controls
  output logic             multiplied_clock_select,
  output logic             multiplier_enable,
  output logic             spread_output_select,
  output logic             pll_run,
  output logic             spread_spectrum_generator_run,
  output logic             lock_unlocked,
  output logic             pfd_ref_tick,
  output logic [2:0]       gen_out_div,
  output logic             mod_active,
  output logic [2:0]       mod_depth,
  output logic [1:0]       mod_period,
  output logic [1:0]       range_select,
  output logic             config_error
);

  // ==========================================================================
  // Reset release
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'h0;
      rst_sync_ff <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ==========================================================================
  // Bus decode
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        req;
  logic        wr_go;
  logic        hit_mult;
  logic        hit_sfa;
  logic        hit_sfb;
  logic        hit_lock;
  logic        hit_lockup;
  logic        hit_spread;

  assign req        = wb_cyc & wb_stb;
  // Write lands on the edge where the master sees ack
  assign wr_go      = req & wb_we & ack_ff & wb_sel[0];
  assign hit_mult   = wb_adr[31:2] == pscc_pkg::IDX_MULT_CTL[29:0];
  assign hit_sfa    = wb_adr[31:2] == pscc_pkg::IDX_SFC_A[29:0];
  assign hit_sfb    = wb_adr[31:2] == pscc_pkg::IDX_SFC_B[29:0];
  assign hit_lock   = wb_adr[31:2] == pscc_pkg::IDX_LOCK[29:0];
  assign hit_lockup = wb_adr[31:2] == pscc_pkg::IDX_LOCKUP[29:0];
  assign hit_spread = wb_adr[31:2] == pscc_pkg::IDX_SPREAD[29:0];

  // ==========================================================================
  // Control registers
  logic       mult_en_ff;
  logic       mult_sel_ff;
  logic       sp_en_ff;
  logic       sp_sel_ff;
  logic [7:0] sfa_ff;
  logic [7:0] sfb_ff;
  logic [2:0] lockup_ff;
  logic       lock_ff;
  logic       nxt_mult_en;
  logic       nxt_mult_sel;
  logic       nxt_sp_en;
  logic       nxt_sp_sel;
  logic       mult_dis_evt;
  logic       mult_on_evt;

  always_comb begin
    nxt_mult_en  = mult_en_ff;
    nxt_mult_sel = mult_sel_ff;
    if (wr_go && hit_mult) begin
      nxt_mult_en  = wb_dat_w[pscc_pkg::MC_EN_BIT];
      // Select refuses one while unlocked and drops with the enable
      nxt_mult_sel = wb_dat_w[pscc_pkg::MC_SEL_BIT] & ~lock_ff & wb_dat_w[pscc_pkg::MC_EN_BIT];
    end else if (!mult_en_ff) begin
      nxt_mult_sel = 1'h0;
    end
  end

  always_comb begin
    nxt_sp_en  = sp_en_ff;
    nxt_sp_sel = sp_sel_ff;
    if (wr_go && hit_spread) begin
      nxt_sp_en  = wb_dat_w[pscc_pkg::SC_EN_BIT];
      nxt_sp_sel = wb_dat_w[pscc_pkg::SC_SEL_BIT] & wb_dat_w[pscc_pkg::SC_EN_BIT];
    end
  end

  assign mult_dis_evt = mult_en_ff & ~nxt_mult_en;
  assign mult_on_evt  = ~mult_en_ff & nxt_mult_en;

  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      mult_en_ff  <= 1'h0;
      mult_sel_ff <= 1'h0;
      sp_en_ff    <= 1'h0;
      sp_sel_ff   <= 1'h0;
    end else begin
      mult_en_ff  <= nxt_mult_en;
      mult_sel_ff <= nxt_mult_sel;
      sp_en_ff    <= nxt_sp_en;
      sp_sel_ff   <= nxt_sp_sel;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sfa_ff    <= pscc_pkg::SFA_RST;
      sfb_ff    <= pscc_pkg::SFB_RST;
      lockup_ff <= pscc_pkg::LOCKUP_RST;
    end else if (wr_go) begin
      if (hit_sfa) begin
        sfa_ff <= wb_dat_w[7:0];
      end
      // Modulation settings are frozen while the generator is enabled
      if (hit_sfb && !sp_en_ff) begin
        sfb_ff <= wb_dat_w[7:0] & pscc_pkg::SFB_WMASK;
      end
      if (hit_lockup) begin
        lockup_ff <= wb_dat_w[2:0];
      end
    end
  end

  // ==========================================================================
  // Lockup timer
  pscc_pkg::pscc_lock_state_t lk_state_ff;
  logic [14:0] lk_cnt_ff;
  logic [14:0] lk_last;
  logic        lockup_done;

  always_comb begin
    unique case (lockup_ff)
      pscc_pkg::LOCKUP_CODE_12: lk_last = LOCKUP_CYC_12 - 15'h1;
      pscc_pkg::LOCKUP_CODE_13: lk_last = LOCKUP_CYC_13 - 15'h1;
      // Prohibited codes fall back to the longest wait
      default:                  lk_last = LOCKUP_CYC_14 - 15'h1;
    endcase
  end

  assign lockup_done = (lk_state_ff == pscc_pkg::LK_COUNT) && (lk_cnt_ff == lk_last) && !mult_dis_evt;

  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      lk_state_ff <= pscc_pkg::LK_IDLE;
      lk_cnt_ff   <= 15'h0;
    end else if (mult_dis_evt) begin
      lk_state_ff <= pscc_pkg::LK_IDLE;
      lk_cnt_ff   <= 15'h0;
    end else if (mult_on_evt) begin
      lk_state_ff <= pscc_pkg::LK_COUNT;
      lk_cnt_ff   <= 15'h0;
    end else begin
      unique case (lk_state_ff)
        pscc_pkg::LK_IDLE: begin
          lk_cnt_ff <= 15'h0;
        end
        pscc_pkg::LK_COUNT: begin
          if (lockup_done) begin
            lk_state_ff <= pscc_pkg::LK_IDLE;
            lk_cnt_ff   <= 15'h0;
          end else begin
            lk_cnt_ff <= lk_cnt_ff + 15'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Lock flag
  logic stop_armed_ff;
  logic intermediate_standby_armed_ff;
  logic lock_set;
  logic lock_clear;
  logic stop_wake;
  logic intermediate_standby_wake;

  assign lock_set   = stop_mode | intermediate_standby | mult_dis_evt
                    | (main_osc_stop & subclock_select);
  assign stop_wake  = stop_armed_ff & ~stop_mode & ost_overflow;
  assign intermediate_standby_wake = intermediate_standby_armed_ff & ~intermediate_standby & intermediate_standby_setup_done;
  assign lock_clear = lockup_done | stop_wake | intermediate_standby_wake;

  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      stop_armed_ff  <= 1'h0;
      intermediate_standby_armed_ff <= 1'h0;
    end else begin
      if (stop_mode && mult_en_ff) begin
        stop_armed_ff <= 1'h1;
      end else if (stop_wake || mult_dis_evt) begin
        stop_armed_ff <= 1'h0;
      end
      if (intermediate_standby && mult_en_ff) begin
        intermediate_standby_armed_ff <= 1'h1;
      end else if (intermediate_standby_wake || mult_dis_evt) begin
        intermediate_standby_armed_ff <= 1'h0;
      end
    end
  end

  // Set wins: an unlock event never gets lost to a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      lock_ff <= pscc_pkg::LOCK_RST;
    end else if (lock_set) begin
      lock_ff <= 1'h1;
    end else if (lock_clear) begin
      lock_ff <= 1'h0;
    end
  end

  // ==========================================================================
  // Generator reference path
  logic       gen_run;
  logic       half_ff;
  logic       gen_in_tick;
  logic [2:0] rdiv_cnt_ff;
  logic [2:0] rdiv_field;
  logic       pfd_ff;

  assign gen_run     = mult_en_ff & sp_en_ff & ~main_osc_stop;
  assign gen_in_tick = gen_run & (~sfa_ff[pscc_pkg::SFA_HALVE_BIT] | half_ff);
  assign rdiv_field  = sfa_ff[pscc_pkg::SFA_RDIV_LSB +: 3];

  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      half_ff     <= 1'h0;
      rdiv_cnt_ff <= 3'h0;
      pfd_ff      <= 1'h0;
    end else if (!gen_run) begin
      half_ff     <= 1'h0;
      rdiv_cnt_ff <= 3'h0;
      pfd_ff      <= 1'h0;
    end else begin
      half_ff <= ~half_ff;
      pfd_ff  <= gen_in_tick && (rdiv_cnt_ff == rdiv_field);
      if (gen_in_tick) begin
        rdiv_cnt_ff <= (rdiv_cnt_ff == rdiv_field) ? 3'h0 : rdiv_cnt_ff + 3'h1;
      end
    end
  end

  // ==========================================================================
  // Registered outputs and output assignments
  logic [2:0] odiv_ff;
  logic       cfg_err_ff;
  logic       mod_act_ff;
  logic       clk_out_ff;
  logic       clk_oe_ff;
  logic [1:0] odiv_code;

  assign odiv_code = sfa_ff[pscc_pkg::SFA_ODIV_LSB +: 2];

  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      odiv_ff    <= 3'h0;
      cfg_err_ff <= 1'h0;
      mod_act_ff <= 1'h0;
      clk_out_ff <= 1'h0;
      clk_oe_ff  <= 1'h0;
    end else begin
      odiv_ff    <= (odiv_code == pscc_pkg::ODIV_CODE_2) ? pscc_pkg::ODIV_RATIO_2 :
                    (odiv_code == pscc_pkg::ODIV_CODE_4) ? pscc_pkg::ODIV_RATIO_4 : 3'h0;
      cfg_err_ff <= (lockup_ff < pscc_pkg::LOCKUP_CODE_12) || (lockup_ff > pscc_pkg::LOCKUP_CODE_14)
                  || (odiv_code != pscc_pkg::ODIV_CODE_2 && odiv_code != pscc_pkg::ODIV_CODE_4)
                  || (sfb_ff[pscc_pkg::SFB_DEPTH_LSB +: 3] > pscc_pkg::DEPTH_MAX)
                  || (sfb_ff[pscc_pkg::SFB_PER_LSB +: 2] == pscc_pkg::PERIOD_BAD);
      mod_act_ff <= gen_run & sfb_ff[pscc_pkg::SFB_MOD_BIT];
      clk_out_ff <= sys_clk_operable & sys_clk_level;
      // Pin floats until the port is switched to output
      clk_oe_ff  <= port_output_mode;
    end
  end

  assign clk_out                 = clk_out_ff;
  assign clk_out_oe              = clk_oe_ff;
  assign multiplied_clock_select = mult_sel_ff;
  assign multiplier_enable       = mult_en_ff;
  assign spread_output_select    = sp_sel_ff;
  assign pll_run                 = mult_en_ff & ~sp_en_ff;
  assign spread_spectrum_generator_run                = gen_run;
  assign lock_unlocked           = lock_ff;
  assign pfd_ref_tick            = pfd_ff;
  assign gen_out_div             = odiv_ff;
  assign mod_active              = mod_act_ff;
  assign mod_depth               = sfb_ff[pscc_pkg::SFB_DEPTH_LSB +: 3];
  assign mod_period              = sfb_ff[pscc_pkg::SFB_PER_LSB +: 2];
  assign range_select            = sfa_ff[pscc_pkg::SFA_RANGE_LSB +: 2];
  assign config_error            = cfg_err_ff;

  // ==========================================================================
  // Read path and acknowledge
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (hit_mult) begin
      rd_byte[pscc_pkg::MC_EN_BIT]  = mult_en_ff;
      rd_byte[pscc_pkg::MC_SEL_BIT] = mult_sel_ff;
    end else if (hit_sfa) begin
      rd_byte = sfa_ff;
    end else if (hit_sfb) begin
      rd_byte = sfb_ff;
    end else if (hit_lock) begin
      rd_byte[0] = lock_ff;
    end else if (hit_lockup) begin
      rd_byte[2:0] = lockup_ff;
    end else if (hit_spread) begin
      rd_byte[pscc_pkg::SC_EN_BIT]  = sp_en_ff;
      rd_byte[pscc_pkg::SC_SEL_BIT] = sp_sel_ff;
    end
  end

  // Unmapped addresses still ack and read zero, so a stray access never hangs
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ack_ff <= 1'h0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= req & ~ack_ff;
      dat_ff <= (req && !ack_ff && !wb_we) ? {24'h0, rd_byte} : 32'h0;
    end
  end

  assign wb_ack   = ack_ff;
  assign wb_dat_r = dat_ff;

  // ==========================================================================
  // Checks
  logic [14:0] en_age_ff;

  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      en_age_ff <= 15'h0;
    end else if (mult_on_evt || !mult_en_ff) begin
      en_age_ff <= 15'h0;
    end else if (en_age_ff != 15'h7fff) begin
      en_age_ff <= en_age_ff + 15'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_ff);

  sequence s_stop_wake;
    stop_armed_ff && !stop_mode && ost_overflow && !lock_set;
  endsequence

  sequence s_intermediate_standby_wake;
    intermediate_standby_armed_ff && !intermediate_standby && intermediate_standby_setup_done && !lock_set;
  endsequence

  a_sel_needs_en: assert property (mult_sel_ff |-> mult_en_ff)
    else $error("clock select high with multiplier disabled");
  a_sel_needs_lock: assert property ($rose(mult_sel_ff) |-> $past(!lock_ff))
    else $error("clock select rose while unlocked");
  a_disable_unlock: assert property ($fell(mult_en_ff) |-> lock_ff && !mult_sel_ff)
    else $error("disable did not unlock and deselect");
  a_standby_unlock: assert property ((stop_mode || intermediate_standby) |=> lock_ff)
    else $error("standby did not unlock");
  a_stop_wake_lock: assert property (s_stop_wake |=> !lock_ff)
    else $error("stop wake did not lock");
  a_intermediate_standby_wake_lock: assert property (s_intermediate_standby_wake |=> !lock_ff)
    else $error("intermediate standby wake did not lock");
  a_lockup_length: assert property (lockup_done |-> en_age_ff == lk_last ##1 !lock_ff || lock_set)
    else $error("lockup ended at wrong count");
  a_spread_sel_en: assert property (sp_sel_ff |-> sp_en_ff)
    else $error("output select high with spread disabled");
  a_gen_stopped: assert property ((!mult_en_ff || main_osc_stop || !sp_en_ff) |-> !spread_spectrum_generator_run ##1 !pfd_ref_tick)
    else $error("generator running when it must stop");
  a_sfb_frozen: assert property ($past(sp_en_ff) |-> sfb_ff == $past(sfb_ff))
    else $error("control B changed while spread enabled");
  a_sfb_zero_bits: assert property ((sfb_ff & ~pscc_pkg::SFB_WMASK) == 8'h00)
    else $error("control B reserved bits set");
  a_ref_tick_cause: assert property (pfd_ref_tick |-> $past(gen_in_tick) && $past(rdiv_cnt_ff == rdiv_field))
    else $error("reference tick without full division");
  a_pin_low: assert property (!sys_clk_operable |=> !clk_out)
    else $error("clock pin not low while clock stopped");

endmodule : pscc_top

`default_nettype wire

// >>> testbench/tb_pscc_top.sv
// Purpose: Self-checking bench for the clock multiplier control block
// Assumes: Lockup counts shortened to 32/64/128 cycles
// Notes:   Register fields drawn at random from a fixed seed
`default_nettype none
module tb_pscc_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals
  logic        core_clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [31:0] wb_adr, wb_dat_w, wb_dat_r, rd;
  logic [3:0]  wb_sel;
  logic        stop_mode, intermediate_standby, ost_overflow, intermediate_standby_setup_done;
  logic        main_osc_stop, subclock_select, sys_clk_level, sys_clk_operable;
  logic        port_output_mode, clk_out, clk_out_oe, multiplied_clock_select;
  logic        multiplier_enable, spread_output_select, pll_run, spread_spectrum_generator_run;
  logic        lock_unlocked, pfd_ref_tick, mod_active, config_error;
  logic [2:0]  gen_out_div, mod_depth;
  logic [1:0]  mod_period, range_select;
  logic [7:0]  v;
  integer      error_cnt = 0, n_tests = 0, cyc_n = 0, t0, i, k;
  integer      seed = 32'haa5e7d82;

  pscc_top #(.LOCKUP_CYC_12(15'h0020), .LOCKUP_CYC_13(15'h0040), .LOCKUP_CYC_14(15'h0080)) i_pscc_top (
    .core_clk, .resetn, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack,
    .stop_mode, .intermediate_standby, .ost_overflow, .intermediate_standby_setup_done, .main_osc_stop,
    .subclock_select, .sys_clk_level, .sys_clk_operable, .port_output_mode, .clk_out, .clk_out_oe,
    .multiplied_clock_select, .multiplier_enable, .spread_output_select, .pll_run, .spread_spectrum_generator_run,
    .lock_unlocked, .pfd_ref_tick, .gen_out_div, .mod_active, .mod_depth, .mod_period,
    .range_select, .config_error);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc_n <= cyc_n + 1;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] ba(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction : ba
  function automatic integer lk(input logic [7:0] c);
    return (c == 8'h02) ? 32 : (c == 8'h03) ? 64 : 128;
  endfunction : lk
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cy(input integer n);
    repeat (n) @(posedge core_clk);
  endtask : cy
  // Called just after an edge; t0 keeps the count at the ack edge
  task automatic bus(input logic we, input logic [31:0] idx, input logic [7:0] d);
    integer w;
    w = 0;
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_sel   <= 4'h1;
    wb_adr   <= ba(idx);
    wb_dat_w <= {24'h000000, d};
    do begin
      @(posedge core_clk);
      w++;
    end while (wb_ack !== 1'b1 && w < 20);
    if (w >= 20) chk(32'h0, 32'h1);
    rd = wb_dat_r;
    t0 = cyc_n;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic wr(input logic [31:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input logic [31:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, e});
  endtask : rdc
  task automatic wlock;
    k = 0;
    while (lock_unlocked !== 1'b0 && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 400) chk(32'h0, 32'h1);
  endtask : wlock
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // Generous span: whole run needs well under 5000 cycles
  initial begin
    #2000000;
    error_cnt++;
    complete_run();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {resetn, wb_cyc, wb_stb, wb_we, stop_mode, intermediate_standby, ost_overflow} = '0;
    {intermediate_standby_setup_done, main_osc_stop, subclock_select, sys_clk_level} = '0;
    {sys_clk_operable, port_output_mode, wb_adr, wb_dat_w, wb_sel} = '0;
    cy(20);
    resetn <= 1'b1;
    cy(4);
    chk({clk_out_oe, lock_unlocked}, 2'b01);
    rdc(pscc_pkg::IDX_LOCK, 8'h01);
    rdc(pscc_pkg::IDX_LOCKUP, 8'h03);
    rdc(pscc_pkg::IDX_SFC_A, 8'h00);
    rdc(pscc_pkg::IDX_SFC_B, 8'h00);
    rdc(32'h00000123, 8'h00);
    wr(pscc_pkg::IDX_MULT_CTL, 8'h02);
    rdc(pscc_pkg::IDX_MULT_CTL, 8'h00);
    // Lockup length for each legal code and one prohibited code
    for (i = 0; i < 4; i++) begin
      v = (i == 3) ? 8'h07 : 8'h02 + i[7:0];
      // Code set only while stopped; counts scaled down stand for the long lockups
      wr(pscc_pkg::IDX_LOCKUP, v);
      wr(pscc_pkg::IDX_MULT_CTL, 8'h01);
      k = t0;
      wr(pscc_pkg::IDX_MULT_CTL, 8'h03);
      rdc(pscc_pkg::IDX_MULT_CTL, 8'h01);
      while (lock_unlocked !== 1'b0 && cyc_n - k < 300) @(posedge core_clk);
      chk(cyc_n - k, lk(v) + 1);
      wr(pscc_pkg::IDX_MULT_CTL, 8'h03);
      rdc(pscc_pkg::IDX_MULT_CTL, 8'h03);
      rdc(pscc_pkg::IDX_LOCK, 8'h00);
      chk({pll_run, spread_spectrum_generator_run, multiplier_enable}, 3'b101);
      wr(pscc_pkg::IDX_MULT_CTL, 8'h00);
      chk({pll_run, multiplied_clock_select, lock_unlocked}, 3'b001);
    end
    wr(pscc_pkg::IDX_LOCKUP, 8'h02);
    wr(pscc_pkg::IDX_MULT_CTL, 8'h01);
    wlock();
    wr(pscc_pkg::IDX_SFC_A, 8'h04);
    v = $random(seed);
    wr(pscc_pkg::IDX_SFC_B, v);
    rdc(pscc_pkg::IDX_SFC_B, v & pscc_pkg::SFB_WMASK);
    chk({mod_depth, mod_period}, {v[6:4], v[1:0]});
    chk(config_error, (v[6:4] > 3'h5) || (v[1:0] == 2'h3));
    wr(pscc_pkg::IDX_SPREAD, 8'h02);
    rdc(pscc_pkg::IDX_SPREAD, 8'h00);
    wr(pscc_pkg::IDX_SPREAD, 8'h03);
    // Settle wait after a late spread enable, scaled like the lockup counts
    cy(40);
    rdc(pscc_pkg::IDX_SPREAD, 8'h03);
    chk({spread_spectrum_generator_run, pll_run, mod_active}, {2'b10, v[7]});
    chk(spread_output_select, 1'b1);
    wr(pscc_pkg::IDX_SFC_B, ~v);
    rdc(pscc_pkg::IDX_SFC_B, v & pscc_pkg::SFB_WMASK);
    // Reference period from halving and divide fields
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      v[3:2] = v[2] ? 2'b01 : 2'b10;
      // Control A only changes with the generator disabled
      wr(pscc_pkg::IDX_SPREAD, 8'h00);
      chk(spread_output_select, 1'b0);
      wr(pscc_pkg::IDX_SFC_A, v);
      wr(pscc_pkg::IDX_SPREAD, 8'h03);
      chk({gen_out_div, range_select}, {v[3] ? 3'h4 : 3'h2, v[1:0]});
      for (k = 0; k < 3; k++) begin
        t0 = cyc_n;
        do @(posedge core_clk); while (pfd_ref_tick !== 1'b1 && cyc_n - t0 < 40);
      end
      t0 = cyc_n;
      do @(posedge core_clk); while (pfd_ref_tick !== 1'b1 && cyc_n - t0 < 40);
      chk(cyc_n - t0, (v[6:4] + 1) * (v[7] ? 2 : 1));
    end
    main_osc_stop   <= 1'b1;
    subclock_select <= 1'b1;
    cy(3);
    chk({spread_spectrum_generator_run, lock_unlocked}, 2'b01);
    main_osc_stop   <= 1'b0;
    subclock_select <= 1'b0;
    wr(pscc_pkg::IDX_MULT_CTL, 8'h00);
    chk(spread_spectrum_generator_run, 1'b0);
    wr(pscc_pkg::IDX_MULT_CTL, 8'h01);
    wlock();
    // Standby entry and wake with the loop running
    stop_mode <= 1'b1;
    cy(3);
    chk(lock_unlocked, 1'b1);
    stop_mode <= 1'b0;
    cy(2);
    ost_overflow <= 1'b1;
    cy(1);
    ost_overflow <= 1'b0;
    cy(3);
    chk(lock_unlocked, 1'b0);
    intermediate_standby <= 1'b1;
    cy(3);
    chk(lock_unlocked, 1'b1);
    intermediate_standby <= 1'b0;
    cy(2);
    intermediate_standby_setup_done <= 1'b1;
    cy(1);
    intermediate_standby_setup_done <= 1'b0;
    cy(3);
    chk(lock_unlocked, 1'b0);
    port_output_mode <= 1'b1;
    sys_clk_operable <= 1'b1;
    sys_clk_level    <= 1'b1;
    cy(3);
    chk({clk_out_oe, clk_out}, 2'b11);
    sys_clk_level <= 1'b0;
    cy(3);
    chk(clk_out, 1'b0);
    sys_clk_level    <= 1'b1;
    sys_clk_operable <= 1'b0;
    cy(3);
    chk(clk_out, 1'b0);
    complete_run();
  end
endmodule : tb_pscc_top
`default_nettype wire
